// File: slbm_defs.vh
`ifndef SLBM_DEFS_VH
`define SLBM_DEFS_VH
// clock rate in kHz, 125 MHz system clock
`define SLBM_CLK_KHZ 125000
// boot period in ms
`define SLBM_BOOT_MS 3000
// trigger idle limit in ms
`define SLBM_IDLE_MS 5000
// one blink phase (green or orange half) in ms
`define SLBM_PHASE_MS 250
// pause between bursts in ms
`define SLBM_PAUSE_MS 2000
// derived cycle counts
`define SLBM_BOOT_CYC (`SLBM_BOOT_MS * `SLBM_CLK_KHZ)
`define SLBM_IDLE_CYC (`SLBM_IDLE_MS * `SLBM_CLK_KHZ)
`define SLBM_PHASE_CYC (`SLBM_PHASE_MS * `SLBM_CLK_KHZ)
`define SLBM_PAUSE_CYC (`SLBM_PAUSE_MS * `SLBM_CLK_KHZ)
// blink counts per fault slot
`define SLBM_NFAULT 5
`define SLBM_CNT_IDLE 4'h3
`define SLBM_CNT_SAVE 4'h5
`define SLBM_CNT_LOAD 4'h6
`define SLBM_CNT_CMDS 4'h7
`define SLBM_CNT_CFG 4'h8
// slot register starts on the last slot so the idle check is shown first
`define SLBM_SLOT_RST 3'h4
`endif

// File: slbm_edge_watch.v
`timescale 1ns/1ps
`default_nettype none
// synchronises the trigger pin and times how long it has been quiet
module slbm_edge_watch #(
  parameter [31:0] IDLE_CYC = 32'h0
) (
  input wire clk,
  input wire reset_n,
  input wire trigIn,
  output reg idleFault_q
);
  reg [2:0] sync_q;
  reg stable_q;
  reg [31:0] idleCnt_q;
  wire agree = (sync_q[1] == sync_q[2]);
  wire edgeSeen = agree && (sync_q[2] != stable_q);

  // three-stage sampler; a level counts once stages two and three agree
  always @(posedge clk) begin
    if (!reset_n) begin
      sync_q <= 3'h0;
      stable_q <= 1'b0;
    end else begin
      sync_q <= {sync_q[1:0], trigIn};
      if (agree) stable_q <= sync_q[2];
    end
  end

  // any edge that passes the sampler restarts the idle timer and clears the fault
  always @(posedge clk) begin
    if (!reset_n) begin
      idleCnt_q <= 32'h0;
      idleFault_q <= 1'b0;
    end else if (edgeSeen) begin
      idleCnt_q <= 32'h0; // [R12]
      idleFault_q <= 1'b0; // [R12]
    end else if (idleCnt_q >= IDLE_CYC - 32'h1) begin
      idleFault_q <= 1'b1; // [R6]
    end else begin
      idleCnt_q <= idleCnt_q + 32'h1;
    end
  end
endmodule
`default_nettype wire

// File: slbm_status_led.v
// Behaviour
// R1: solid orange throughout boot period
// R2: steady orange when healthy after boot
// R3: continuous checks; fault makes green/orange blinking
// R4: blink count per burst names fault
// R5: several faults shown in turn
// R6: trigger quiet five seconds gives 3 blinks
// R7: parameter save failure gives 5 blinks
// R8: parameter load failure gives 6 blinks
// R9: missing command list gives 7 blinks
// R10: logic configuration failure gives 8 blinks
// R11: long pause separates bursts, durations parameters
// R12: trigger edge restarts timer, clears fault
`include "slbm_defs.vh"
`timescale 1ns/1ps
`default_nettype none
module slbm_status_led #(
  parameter [31:0] BOOT_CYC = `SLBM_BOOT_CYC,
  parameter [31:0] IDLE_CYC = `SLBM_IDLE_CYC,
  parameter [31:0] PHASE_CYC = `SLBM_PHASE_CYC,
  parameter [31:0] PAUSE_CYC = `SLBM_PAUSE_CYC
) (
  input wire clk,
  input wire reset_n,
  input wire external_frame_trigger,
  input wire saveFail,
  input wire loadFail,
  input wire cmdListMissing,
  input wire logicCfgFail,
  output reg ledGreen_q,
  output reg ledOrange_q,
  output reg bootDone_q,
  output wire idleFault
);
  localparam [1:0] ST_BOOT = 2'h0;
  localparam [1:0] ST_IDLE = 2'h1;
  localparam [1:0] ST_BLINK = 2'h2;
  localparam [1:0] ST_PAUSE = 2'h3;

  reg [1:0] state_q;
  reg [31:0] timer_q;
  reg [2:0] slot_q;
  reg [3:0] blinks_q;
  reg phase_q;
  wire [4:0] faults;
  reg [1:0] state_d;
  reg [31:0] timer_d;
  reg [2:0] slot_d;
  reg [3:0] blinks_d;
  reg phase_d;
  reg bootDone_d;
  reg ledGreen_d;
  reg ledOrange_d;
  wire timerEnd;
  wire [3:0] burstLen;
  wire burstEnd;

  // blink count for each fault slot
  function [3:0] slotCount;
    input [2:0] s;
    begin
      case (s)
        3'h0: slotCount = `SLBM_CNT_IDLE; // [R6] [R4]
        3'h1: slotCount = `SLBM_CNT_SAVE; // [R7]
        3'h2: slotCount = `SLBM_CNT_LOAD; // [R8]
        3'h3: slotCount = `SLBM_CNT_CMDS; // [R9]
        default: slotCount = `SLBM_CNT_CFG; // [R10]
      endcase
    end
  endfunction

  // next active slot after the given one, wrapping round
  function [2:0] nextSlot;
    input [2:0] s;
    input [4:0] f;
    integer i;
    reg [2:0] c;
    reg found;
    begin
      nextSlot = s;
      found = 1'b0;
      c = s;
      for (i = 0; i < `SLBM_NFAULT; i = i + 1) begin
        c = (c == 3'h4) ? 3'h0 : c + 3'h1;
        if (!found && f[c]) begin
          nextSlot = c;
          found = 1'b1;
        end
      end
    end
  endfunction

  // last timer count of each timed state
  function [31:0] lastCount;
    input [1:0] st;
    begin
      case (st)
        ST_BOOT: lastCount = BOOT_CYC - 32'h1;
        ST_BLINK: lastCount = PHASE_CYC - 32'h1;
        default: lastCount = PAUSE_CYC - 32'h1;
      endcase
    end
  endfunction

  slbm_edge_watch #(.IDLE_CYC(IDLE_CYC)) uWatch (
    .clk(clk),
    .reset_n(reset_n),
    .trigIn(external_frame_trigger),
    .idleFault_q(idleFault)
  );

  // flags come from logic on this clock, so no sampler is needed
  assign faults = {logicCfgFail, cmdListMissing, loadFail, saveFail, idleFault};

  // one shared end-of-count compare keeps the three timed states alike
  assign timerEnd = (timer_q >= lastCount(state_q));

  // burst length is fixed once the slot is chosen
  assign burstLen = slotCount(slot_q);
  assign burstEnd = (blinks_q + 4'h1 >= burstLen);

  // boot hold, then healthy/blink/pause sequencing
  always @* begin
    state_d = state_q;
    timer_d = timer_q;
    slot_d = slot_q;
    blinks_d = blinks_q;
    phase_d = phase_q;
    bootDone_d = bootDone_q;
    ledGreen_d = ledGreen_q;
    ledOrange_d = ledOrange_q;
    case (state_q)
      ST_BOOT: begin
        // nothing is reported until the boot hold ends
        ledGreen_d = 1'b0;
        ledOrange_d = 1'b1; // [R1]
        if (timerEnd) begin
          timer_d = 32'h0;
          bootDone_d = 1'b1;
          state_d = ST_IDLE;
        end else begin
          timer_d = timer_q + 32'h1;
        end
      end
      ST_IDLE: begin
        ledGreen_d = 1'b0;
        ledOrange_d = 1'b1; // [R2]
        timer_d = 32'h0;
        if (|faults) begin
          // a burst always starts on green, then alternates
          slot_d = nextSlot(slot_q, faults); // [R3] [R5]
          blinks_d = 4'h0;
          phase_d = 1'b0;
          state_d = ST_BLINK;
        end
      end
      ST_BLINK: begin
        ledGreen_d = ~phase_q; // [R3]
        ledOrange_d = phase_q;
        if (timerEnd) begin
          timer_d = 32'h0;
          phase_d = ~phase_q;
          if (phase_q) begin
            // one blink is a green half plus an orange half
            if (burstEnd) begin
              state_d = ST_PAUSE; // [R4]
            end
            blinks_d = blinks_q + 4'h1;
          end
        end else begin
          timer_d = timer_q + 32'h1;
        end
      end
      ST_PAUSE: begin
        // steady orange pause lets the operator count the burst
        ledGreen_d = 1'b0;
        ledOrange_d = 1'b1; // [R11]
        if (timerEnd) begin
          timer_d = 32'h0;
          state_d = ST_IDLE; // [R5]
        end else begin
          timer_d = timer_q + 32'h1;
        end
      end
      default: begin
        // unused code falls back to the healthy state
        state_d = ST_IDLE;
        timer_d = 32'h0;
      end
    endcase
  end

  // sequencer registers
  always @(posedge clk) begin
    if (!reset_n) begin
      state_q <= ST_BOOT;
      timer_q <= 32'h0;
      slot_q <= `SLBM_SLOT_RST;
      blinks_q <= 4'h0;
      phase_q <= 1'b0;
    end else begin
      state_q <= state_d;
      timer_q <= timer_d;
      slot_q <= slot_d;
      blinks_q <= blinks_d;
      phase_q <= phase_d;
    end
  end

  // registered LED drive, so the pins never glitch between colours
  always @(posedge clk) begin
    if (!reset_n) begin
      bootDone_q <= 1'b0;
      ledGreen_q <= 1'b0;
      ledOrange_q <= 1'b1;
    end else begin
      bootDone_q <= bootDone_d;
      ledGreen_q <= ledGreen_d;
      ledOrange_q <= ledOrange_d;
    end
  end
endmodule
`default_nettype wire

// File: slbm_chk_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module slbm_chk_assertions (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic external_frame_trigger,
  input wire logic saveFail,
  input wire logic loadFail,
  input wire logic cmdListMissing,
  input wire logic logicCfgFail,
  input wire logic ledGreen_q,
  input wire logic ledOrange_q,
  input wire logic bootDone_q,
  input wire logic idleFault
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  wire anyF = saveFail | loadFail | cmdListMissing | logicCfgFail | idleFault;
  // one blink, sized for the small phase used on the bench
  sequence blink1;
    ledGreen_q [*4] ##1 ledOrange_q [*4];
  endsequence
  // pin long quiet while the fault stands
  sequence trigQuiet;
    (idleFault && $stable(external_frame_trigger)) [*4];
  endsequence
  // one clean level change, held long enough to pass the sampler
  sequence trigMoved;
    $changed(external_frame_trigger) ##1 $stable(external_frame_trigger) [*2];
  endsequence
  AST_ONEHOT: assert property (ledGreen_q != ledOrange_q) else $error("colours clash");
  AST_BOOT_ORANGE: assert property (!bootDone_q |-> ledOrange_q) else $error("boot not orange");
  AST_BOOT_LEN: assert property ($rose(bootDone_q) |-> $past(reset_n, 20) && !$past(reset_n, 21))
    else $error("boot length");
  AST_STAYS: assert property (bootDone_q |=> bootDone_q) else $error("boot lost");
  AST_PHASE: assert property ($rose(ledGreen_q) |-> blink1) else $error("phase length");
  AST_CAUSE: assert property ($rose(ledGreen_q) |-> $past(anyF, 2) || $past(ledGreen_q, 5))
    else $error("blink without fault");
  AST_IDLE_SET: assert property ($rose(idleFault) |-> $past(external_frame_trigger, 10) == external_frame_trigger)
    else $error("idle while active");
  AST_IDLE_CLR: assert property (trigQuiet ##1 trigMoved |-> ##[1:4] !idleFault)
    else $error("idle not cleared");
endmodule
`default_nettype wire

// File: slbm_led_obs.sv
`timescale 1ns/1ps
`default_nettype none
module slbm_led_obs #(
  parameter int LONG = 8
) (
  input wire logic clk,
  input wire logic ledGreen,
  input wire logic ledOrange,
  output logic [3:0] burstCnt = 4'h0,
  output logic burstDone = 1'b0
);
  logic [3:0] cnt_q = 4'h0;
  logic [7:0] dark_q = 8'h0;
  logic prevG_q = 1'b0;
  // an operator counts green flashes; only a long orange stretch ends a burst
  always @(posedge clk) begin
    prevG_q <= ledGreen;
    burstDone <= 1'b0;
    if (ledGreen && !prevG_q) begin
      cnt_q <= cnt_q + 4'h1;
      dark_q <= 8'h0;
    end else if (ledOrange && cnt_q != 4'h0) begin
      dark_q <= dark_q + 8'h1;
      if (dark_q == LONG) begin
        burstDone <= 1'b1;
        burstCnt <= cnt_q;
        cnt_q <= 4'h0;
      end
    end
  end
endmodule
`default_nettype wire

// File: test_slbm_status_led.sv
`include "slbm_defs.vh"
`timescale 1ns/1ps
`default_nettype none
module test_slbm_status_led;
  logic flip = 0;
  logic clk = 0, reset_n = 0, trig = 0, runTrig = 1, ledGreen_q, ledOrange_q, bootDone_q, idleFault, burstDone;
  logic [3:0] flt = 4'h0, burstCnt, a, b;
  logic [31:0] rnd = 32'h4ba4;
  int error_cnt = 0, comparisons = 0;
  always #4 clk = ~clk;
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    return x ^ (x << 5);
  endfunction
  // random trigger activity keeps the idle check quiet
  always @(posedge clk) begin
    rnd <= xs(rnd);
    if (runTrig) trig <= rnd[0];
    else if (flip) trig <= ~trig;
  end
  // blink count expected for a fault slot, slot 0 is the idle check
  function automatic logic [3:0] expBlinks(input int s);
    case (s)
      0: return `SLBM_CNT_IDLE;
      1: return `SLBM_CNT_SAVE;
      2: return `SLBM_CNT_LOAD;
      3: return `SLBM_CNT_CMDS;
      default: return `SLBM_CNT_CFG;
    endcase
  endfunction
  slbm_status_led #(.BOOT_CYC(20), .IDLE_CYC(50), .PHASE_CYC(4), .PAUSE_CYC(16)) i_dut (.clk(clk),
    .reset_n(reset_n), .external_frame_trigger(trig), .saveFail(flt[0]), .loadFail(flt[1]),
    .cmdListMissing(flt[2]), .logicCfgFail(flt[3]), .ledGreen_q(ledGreen_q), .ledOrange_q(ledOrange_q),
    .bootDone_q(bootDone_q), .idleFault(idleFault));
  slbm_led_obs #(.LONG(8)) i_obs (.clk(clk), .ledGreen(ledGreen_q), .ledOrange(ledOrange_q),
    .burstCnt(burstCnt), .burstDone(burstDone));
  task chk(input logic [3:0] seen, input logic [3:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %0h want %0h", $time, seen, exp);
    end
  endtask
  // bounded wait for the observer to report one burst
  task get(output logic [3:0] c);
    for (int i = 0; i < 2000 && burstDone !== 1'b1; i++) @(negedge clk);
    if (burstDone !== 1'b1) begin
      error_cnt++;
      close_out;
    end
    c = burstCnt;
    @(negedge clk);
  endtask
  task close_out;
    $display("errors %0d of %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge clk);
    reset_n <= 1;
    repeat (10) @(negedge clk);
    chk(ledOrange_q, 1);
    repeat (14) @(negedge clk);
    chk(bootDone_q, 1);
    repeat (30) @(negedge clk);
    chk(ledOrange_q, 1);
    for (int i = 0; i < 4; i++) begin
      @(posedge clk) flt <= 4'h1 << i;
      get(a);
      chk(a, expBlinks(i + 1));
      @(posedge clk) flt <= 4'h0;
    end
    @(posedge clk) runTrig <= 0;
    get(a);
    chk(a, expBlinks(0));
    chk(idleFault, 1);
    @(posedge clk) flip <= 1;
    @(posedge clk) flip <= 0;
    repeat (10) @(negedge clk);
    chk(idleFault, 0);
    @(posedge clk) runTrig <= 1;
    @(posedge clk) flt <= 4'h9;
    get(a);
    get(b);
    chk(a, expBlinks(1));
    chk(b, expBlinks(4));
    close_out;
  end
  // cut a hang short
  initial begin
    #(8 * 20000);
    error_cnt++;
    close_out;
  end
endmodule
bind slbm_status_led slbm_chk_assertions i_chk (.clk(clk), .reset_n(reset_n),
  .external_frame_trigger(external_frame_trigger), .saveFail(saveFail), .loadFail(loadFail),
  .cmdListMissing(cmdListMissing), .logicCfgFail(logicCfgFail), .ledGreen_q(ledGreen_q),
  .ledOrange_q(ledOrange_q), .bootDone_q(bootDone_q), .idleFault(idleFault));
`default_nettype wire
